// ### fesp_consts.svh
/*
 fesp_consts.svh: command codes, register offsets, status bit positions and
 timing counts of the flash erase suspend / protect controller.
 Assumes a single 10 MHz core clock; included by bare name where needed.
*/
`ifndef FESP_CONSTS_SVH
`define FESP_CONSTS_SVH

// command bytes seen on a flash write
`define FESP_CMD_SUSPEND 8'hB0
`define FESP_CMD_RESUME 8'h30
`define FESP_CMD_RESET 8'hF0
// optional unlock prefix cycles
`define FESP_UNLK1_ADDR 16'h0555
`define FESP_UNLK1_DATA 8'hAA
`define FESP_UNLK2_ADDR 16'h0AAA
`define FESP_UNLK2_DATA 8'h55
// offsets of the lock status registers in the control register space
`define FESP_MAIN_LOCK_OFS 8'hC0
`define FESP_SEC_LOCK_OFS 8'hC2
// byte returned for the sector whose erase is suspended
`define FESP_INVALID_DATA 8'hFF
// status byte fields
`define FESP_ST_POLL 7
`define FESP_ST_TOGGLE 6
`define FESP_ST_ERR 5
`define FESP_ST_WIN 3
`define FESP_SEC_LOCK_BIT 7
// times in ns and their cycle counts
`define FESP_CLK_NS 100
`define FESP_SUSP_MIN_NS 100
`define FESP_SUSP_MAX_NS 15000
`define FESP_RST_MAX_NS 25000
`define FESP_WIN_NS 100000
`define FESP_SUSP_CYC ((`FESP_SUSP_MIN_NS + `FESP_CLK_NS - 1) / `FESP_CLK_NS)
`define FESP_RST_CYC (`FESP_RST_MAX_NS / `FESP_CLK_NS)
`define FESP_WIN_CYC (`FESP_WIN_NS / `FESP_CLK_NS)

`endif

// ### fesp_pkg.sv
/*
 fesp_pkg.sv: types shared by the controller files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package fesp_pkg;
	// erase controller states
	typedef enum logic [2:0] {
		ST_READ, ST_WINDOW, ST_ERASE, ST_SUSPENDING, ST_SUSPENDED, ST_RECOVER
	} fesp_state_t;
	// timer tick count
	typedef logic [9:0] fesp_tick_t;
	// one bit per sector: boot sectors in [11:8], main sectors in [7:0]
	typedef logic [11:0] fesp_sect_t;
endpackage : fesp_pkg
`default_nettype wire

// ### fesp_timer.sv
/*
 fesp_timer.sv: loadable down counter giving a one-cycle done pulse.
 Assumes load and count come from the core clock domain.
*/
`default_nettype none
module fesp_timer (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire fesp_pkg::fesp_tick_t count,
	output logic done
);
	import fesp_pkg::*;

	fesp_tick_t cnt_reg; // remaining cycles
	fesp_tick_t cnt_next;

	// a load restarts the count; zero means idle
	assign cnt_next = load ? count : (cnt_reg != '0) ? cnt_reg - fesp_tick_t'(1) : cnt_reg;
	// done fires N cycles after a load of N
	assign done = (cnt_reg == fesp_tick_t'(1)) && !load;

	// counter register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule : fesp_timer
`default_nettype wire

// ### fesp_sel_prio.sv
/*
 fesp_sel_prio.sv: priority between decoded selects.
 Assumes the selects arrive from the address decode array, all level signals.
*/
`default_nettype none
module fesp_sel_prio (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] main_sector_selects,
	input wire logic [3:0] boot_sector_selects,
	input wire logic sram_select,
	input wire logic control_register_space,
	input wire logic pio_select,
	output logic [7:0] main_sector_enable,
	output logic [3:0] boot_sector_enable,
	output logic sram_enable,
	output logic creg_enable,
	output logic pio_enable
);
	import fesp_pkg::*;

	logic io_hit; // any of the three top-level regions
	logic boot_hit; // any secondary sector

	assign io_hit = sram_select | control_register_space | pio_select;
	assign boot_hit = |boot_sector_selects;
	// io regions win over flash sectors
	assign sram_enable = sram_select;
	// fixed order keeps the enables exclusive even if software overlaps them
	assign creg_enable = control_register_space & ~sram_select;
	assign pio_enable = pio_select & ~sram_select & ~control_register_space;
	assign boot_sector_enable = io_hit ? 4'h0 : boot_sector_selects;
	// secondary sector wins an overlap with a primary sector
	assign main_sector_enable = (io_hit | boot_hit) ? 8'h00 : main_sector_selects;

	// at most one region granted per access
	property p_one_region;
		@(posedge core_clk) disable iff (sys_rst)
		$onehot0({sram_enable, creg_enable, pio_enable, |boot_sector_enable,
			|main_sector_enable});
	endproperty
	a_one_region: assert property (p_one_region) else $error("two regions enabled");
	property p_boot_over_main;
		@(posedge core_clk) disable iff (sys_rst)
		(|boot_sector_selects) |-> (main_sector_enable == 8'h00);
	endproperty
	a_boot_over_main: assert property (p_boot_over_main) else $error("main over boot");
endmodule : fesp_sel_prio
`default_nettype wire

// ### fesp_ctrl.sv
/*
 fesp_ctrl.sv: flash erase suspend / resume, sector protection, flash reset
 and select priority for the MCU-facing flash port.
 Assumes bus_wr and bus_rd are one-cycle strobes synchronous to core_clk, the
 sector selects come from the address decode array, and the program and erase
 algorithms sit outside and follow erase_run and erase_abort.
*/
`default_nettype none
`include "fesp_consts.svh"

module fesp_ctrl (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic flash_rst_n,
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] main_sector_selects,
	input wire logic [3:0] boot_sector_selects,
	input wire logic sram_select,
	input wire logic control_register_space,
	input wire logic pio_select,
	input wire logic [7:0] main_sector_lock,
	input wire logic [3:0] boot_sector_lock,
	input wire logic security_lock,
	input wire logic [7:0] array_rdata,
	input wire logic sector_erase_cmd,
	input wire logic prog_req,
	input wire logic prog_active,
	input wire logic bulk_active,
	input wire logic erase_done,
	input wire logic erase_fail,
	output fesp_pkg::fesp_sect_t erase_target,
	output logic erase_run,
	output logic erase_abort,
	output logic prog_grant,
	output fesp_pkg::fesp_sect_t sector_invalid,
	output logic [7:0] main_sector_enable,
	output logic [3:0] boot_sector_enable,
	output logic sram_enable,
	output logic creg_enable,
	output logic pio_enable
);
	import fesp_pkg::*;

	fesp_state_t state_reg; // erase controller state
	fesp_state_t state_next;
	fesp_sect_t target_reg; // sectors being erased
	fesp_sect_t target_next;
	fesp_sect_t invalid_reg; // sectors left corrupt by a reset
	fesp_sect_t invalid_next;
	logic toggle_reg; // toggle status bit
	logic err_reg; // error status bit
	logic abort_reg; // abort pulse to the algorithms
	logic [7:0] rdata_reg; // read data register
	logic [7:0] rdata_next;

	fesp_sect_t sel_vec; // resolved sector selects
	fesp_sect_t lock_vec; // protection bits per sector
	fesp_sect_t erase_mask; // unlocked sectors of a new erase request
	logic flash_hit; // a flash sector is addressed
	logic in_target; // the addressed sector is under erase
	logic wr_flash; // write strobe to flash space
	logic cmd_suspend, cmd_resume, cmd_reset;
	logic reset_ok; // reset command that is not ignored
	logic is_unlock; // unlock prefix cycle
	logic erase_ok; // new erase request accepted
	logic busy_view; // reads return status rather than data
	logic pin_abort; // reset pin forces recovery
	logic tmr_load; // restart the shared timer
	fesp_tick_t tmr_count;
	logic tmr_done;
	logic [7:0] status_byte;
	logic [7:0] sec_lock_byte;
	logic [7:0] creg_byte;
	logic susp_state; // suspend latency or suspended

	// priority among the decoded selects
	fesp_sel_prio u_prio (
		.core_clk(core_clk), .sys_rst(sys_rst), .sram_select(sram_select),
		.main_sector_selects(main_sector_selects), .pio_select(pio_select),
		.boot_sector_selects(boot_sector_selects), .sram_enable(sram_enable),
		.control_register_space(control_register_space), .creg_enable(creg_enable),
		.main_sector_enable(main_sector_enable), .pio_enable(pio_enable),
		.boot_sector_enable(boot_sector_enable)
	);

	// one timer serves window, suspend latency and recovery; they never overlap
	fesp_timer u_timer (
		.core_clk(core_clk), .sys_rst(sys_rst), .load(tmr_load),
		.count(tmr_count), .done(tmr_done)
	);

	// address and command decode
	assign sel_vec = {boot_sector_enable, main_sector_enable};
	assign lock_vec = {boot_sector_lock, main_sector_lock};
	assign flash_hit = |sel_vec;
	assign in_target = |(sel_vec & target_reg);
	assign wr_flash = bus_wr & flash_hit;
	assign cmd_suspend = wr_flash && (bus_wdata == `FESP_CMD_SUSPEND);
	assign cmd_resume = wr_flash && (bus_wdata == `FESP_CMD_RESUME);
	// one write is enough; unlock cycles before it are simply absorbed
	assign cmd_reset = bus_wr && (bus_wdata == `FESP_CMD_RESET);
	assign is_unlock = bus_wr && (((bus_addr == `FESP_UNLK1_ADDR) &&
		(bus_wdata == `FESP_UNLK1_DATA)) || ((bus_addr == `FESP_UNLK2_ADDR) &&
		(bus_wdata == `FESP_UNLK2_DATA)));
	assign reset_ok = cmd_reset & ~is_unlock & ~prog_active & ~bulk_active;
	assign pin_abort = !flash_rst_n;
	// locked sectors drop out of an erase request silently
	assign erase_mask = sel_vec & ~lock_vec;
	assign erase_ok = sector_erase_cmd && (erase_mask != '0) && !prog_active &&
		!bulk_active && ((state_reg == ST_READ) || (state_reg == ST_WINDOW));
	// programming only from plain read mode into an unlocked sector
	assign prog_grant = prog_req && (state_reg == ST_READ) && !pin_abort &&
		((sel_vec & lock_vec) == '0);
	assign susp_state = (state_reg == ST_SUSPENDING) || (state_reg == ST_SUSPENDED);
	assign busy_view = in_target && ((state_reg == ST_WINDOW) ||
		(state_reg == ST_ERASE) || (state_reg == ST_SUSPENDING) || err_reg);

	// next state and timer control
	always_comb begin
		state_next = state_reg;
		target_next = target_reg;
		invalid_next = invalid_reg;
		tmr_load = 1'b0;
		tmr_count = fesp_tick_t'(`FESP_WIN_CYC);
		case (state_reg)
			ST_READ: begin
				if (erase_ok) begin
					state_next = ST_WINDOW;
					target_next = erase_mask;
					tmr_load = 1'b1;
				end else if (reset_ok && err_reg) begin
					// error cleanup goes through the bounded recovery
					state_next = ST_RECOVER;
					tmr_load = 1'b1;
					tmr_count = fesp_tick_t'(`FESP_RST_CYC);
				end
			end
			ST_WINDOW: begin
				if (cmd_suspend) begin
					// suspend also kills the accumulation window
					state_next = ST_SUSPENDING;
					tmr_load = 1'b1;
					tmr_count = fesp_tick_t'(`FESP_SUSP_CYC);
				end else if (reset_ok) begin
					state_next = ST_RECOVER;
					tmr_load = 1'b1;
					tmr_count = fesp_tick_t'(`FESP_RST_CYC);
				end else if (erase_ok) begin
					// another sector restarts the window
					target_next = target_reg | erase_mask;
					tmr_load = 1'b1;
				end else if (tmr_done) begin
					state_next = ST_ERASE;
				end
			end
			ST_ERASE: begin
				if (cmd_suspend) begin
					state_next = ST_SUSPENDING;
					tmr_load = 1'b1;
					tmr_count = fesp_tick_t'(`FESP_SUSP_CYC);
				end else if (reset_ok) begin
					state_next = ST_RECOVER;
					tmr_load = 1'b1;
					tmr_count = fesp_tick_t'(`FESP_RST_CYC);
				end else if (erase_done || erase_fail) begin
					state_next = ST_READ;
					target_next = erase_fail ? target_reg : '0;
				end
			end
			ST_SUSPENDING: begin
				// toggling stops and read mode follows after the latency
				if (tmr_done) begin
					state_next = ST_SUSPENDED;
				end
			end
			ST_SUSPENDED: begin
				if (reset_ok) begin
					// the half-erased sectors are now garbage
					invalid_next = invalid_reg | target_reg;
					state_next = ST_RECOVER;
					tmr_load = 1'b1;
					tmr_count = fesp_tick_t'(`FESP_RST_CYC);
				end else if (cmd_resume) begin
					state_next = ST_ERASE;
				end
			end
			ST_RECOVER: begin
				if (tmr_done) begin
					state_next = ST_READ;
					target_next = '0;
				end
			end
			default: begin
				state_next = ST_READ;
			end
		endcase
		// reset pin overrides everything except idle read mode with no program or bulk active, and holds recovery while low
		if (pin_abort && ((state_reg != ST_READ) || prog_active || bulk_active)) begin
			state_next = ST_RECOVER;
			tmr_load = 1'b1;
			tmr_count = fesp_tick_t'(`FESP_RST_CYC);
			if (susp_state) begin
				invalid_next = invalid_reg | target_reg;
			end
		end
		// a completed erase clears the corrupt mark of its sectors
		if ((state_reg == ST_ERASE) && erase_done) begin
			invalid_next = invalid_next & ~target_reg;
		end
	end

	// status byte seen when polling a sector under erase
	assign status_byte = {1'b0, toggle_reg, err_reg, 1'b0,
		state_reg != ST_WINDOW, 3'b000};
	// secondary lock register layout, unused bits read zero
	assign sec_lock_byte = {security_lock, 3'b000, boot_sector_lock};
	// lock registers are read-only; writes to them are dropped
	assign creg_byte = (bus_addr[7:0] == `FESP_MAIN_LOCK_OFS) ? main_sector_lock :
		(bus_addr[7:0] == `FESP_SEC_LOCK_OFS) ? sec_lock_byte : 8'h00;
	// read data selection
	assign rdata_next = creg_enable ? creg_byte :
		busy_view ? status_byte :
		(state_reg == ST_SUSPENDED && in_target) ? `FESP_INVALID_DATA :
		array_rdata; // locked sectors verify as plain reads

	// state and sector masks
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= ST_READ;
			target_reg <= '0;
			invalid_reg <= '0;
		end else begin
			state_reg <= state_next;
			target_reg <= target_next;
			invalid_reg <= invalid_next;
		end
	end

	// toggle bit flips on each read of the erasing sector, also after resume
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			toggle_reg <= 1'b0;
		end else if (bus_rd && in_target &&
			((state_reg == ST_WINDOW) || (state_reg == ST_ERASE))) begin
			toggle_reg <= ~toggle_reg;
		end
	end

	// error bit: a timeout sets it and a reset clears it; the set wins
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			err_reg <= 1'b0;
		end else if ((state_reg == ST_ERASE) && erase_fail) begin
			err_reg <= 1'b1;
		end else if (reset_ok || (state_reg == ST_RECOVER)) begin
			err_reg <= 1'b0;
		end
	end
	// abort pulse on entry to recovery and read data register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			abort_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			abort_reg <= (state_next == ST_RECOVER) && (state_reg != ST_RECOVER);
			if (bus_rd) begin
				rdata_reg <= rdata_next;
			end
		end
	end
	assign bus_rdata = rdata_reg;
	assign erase_target = target_reg;
	assign sector_invalid = invalid_reg;
	// the algorithm pauses whenever this drops
	assign erase_run = (state_reg == ST_ERASE);
	assign erase_abort = abort_reg;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_susp_only_erase;
		(state_reg == ST_READ) && cmd_suspend && !erase_ok && !pin_abort
			&& !reset_ok |=> (state_reg == ST_READ);
	endproperty
	a_susp_only_erase: assert property (p_susp_only_erase) else $error("suspend outside erase");
	property p_win_end;
		(state_reg == ST_WINDOW) && cmd_suspend && flash_rst_n
			|=> (state_reg == ST_SUSPENDING) ##1 (state_reg == ST_SUSPENDED);
	endproperty
	a_win_end: assert property (p_win_end) else $error("window not ended by suspend");
	property p_susp_lat;
		(state_reg == ST_SUSPENDING) |-> ##[1:150] (state_reg != ST_SUSPENDING);
	endproperty
	a_susp_lat: assert property (p_susp_lat) else $error("suspend latency too long");
	property p_invalid;
		bus_rd && (state_reg == ST_SUSPENDED) && in_target && !creg_enable && !err_reg
			|=> (bus_rdata == `FESP_INVALID_DATA);
	endproperty
	a_invalid: assert property (p_invalid) else $error("suspended sector data leaked");
	property p_no_prog;
		susp_state |-> !prog_grant;
	endproperty
	a_no_prog: assert property (p_no_prog) else $error("program while suspended");
	property p_corrupt;
		(state_reg == ST_SUSPENDED) && reset_ok
			|=> ((sector_invalid & $past(target_reg)) == $past(target_reg));
	endproperty
	a_corrupt: assert property (p_corrupt) else $error("suspended sector not invalid");
	property p_resume;
		(state_reg == ST_SUSPENDED) && cmd_resume && !reset_ok && flash_rst_n
			|=> erase_run;
	endproperty
	a_resume: assert property (p_resume) else $error("resume ignored");
	property p_lock_prog;
		prog_grant |-> ((sel_vec & lock_vec) == '0);
	endproperty
	a_lock_prog: assert property (p_lock_prog) else $error("program to locked sector");
	property p_lock_erase;
		erase_ok |=> ((target_reg & lock_vec) == '0);
	endproperty
	a_lock_erase: assert property (p_lock_erase) else $error("erase of locked sector");
	property p_reg_main;
		bus_rd && creg_enable && (bus_addr[7:0] == `FESP_MAIN_LOCK_OFS)
			|=> (bus_rdata == $past(main_sector_lock));
	endproperty
	a_reg_main: assert property (p_reg_main) else $error("main lock readback wrong");
	property p_ignore_reset;
		cmd_reset && (prog_active || bulk_active) && flash_rst_n
			|=> !erase_abort;
	endproperty
	a_ignore_reset: assert property (p_ignore_reset) else $error("reset not ignored");
	property p_recover;
		disable iff (sys_rst || !flash_rst_n)
		(state_reg != ST_RECOVER) ##1 (state_reg == ST_RECOVER)
			|-> ##[1:250] (state_reg == ST_READ);
	endproperty
	a_recover: assert property (p_recover) else $error("recovery too slow");

	c_suspend_resume: cover property ((state_reg == ST_SUSPENDED) ##[1:20] erase_run);
	c_reset_suspended: cover property ((state_reg == ST_SUSPENDED) && reset_ok);
	c_pin_abort: cover property (erase_run && pin_abort);
endmodule : fesp_ctrl
`default_nettype wire

// ### fesp_flash_model.sv
/*
 fesp_flash_model.sv: stand-in for the flash array and its erase algorithm.
 Assumes erase_run and erase_abort come from the controller on core_clk.
*/
`default_nettype none
module fesp_flash_model #(
	parameter int ERASE_CYC = 200
) (
	input wire logic core_clk,
	input wire logic erase_run,
	input wire logic erase_abort,
	input wire logic [15:0] bus_addr,
	input wire logic fail_arm,
	output logic [7:0] array_rdata,
	output logic erase_done,
	output logic erase_fail
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt_reg = 0; // running time of the erase, kept while suspended
	logic at_end; // last running cycle of the erase
	// stored byte follows the address, so a stale byte never passes for a fresh one
	assign array_rdata = bus_addr[7:0] ^ 8'h5a;
	assign at_end = erase_run && (cnt_reg == ERASE_CYC - 1);
	// erase ends after ERASE_CYC running cycles, as a failure while the bench arms one;
	// any ending or abort restarts the count, so no erase inherits a stale count
	always_ff @(posedge core_clk) begin
		erase_done <= at_end && !fail_arm;
		erase_fail <= at_end && fail_arm;
		if (erase_abort || erase_done || erase_fail || at_end) begin
			cnt_reg <= 0;
		end else if (erase_run) begin
			cnt_reg <= cnt_reg + 1;
		end
	end
endmodule : fesp_flash_model
`default_nettype wire

// ### tb_top.sv
/*
 tb_top.sv: self-checking bench of the erase suspend / protect controller.
 Assumes the controller, its timer, select priority and flash model beside it.
*/
`default_nettype none
`include "fesp_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import fesp_pkg::*;
	logic core_clk = 0, sys_rst = 1, flash_rst_n = 1, bus_wr = 0, bus_rd = 0;
	logic [15:0] bus_addr = 0;
	logic [7:0] bus_wdata = 0, bus_rdata, array_rdata, main_sector_enable, r1, r2;
	logic [7:0] main_sector_selects = 0, main_sector_lock = 0;
	logic [3:0] boot_sector_selects = 0, boot_sector_lock = 0, boot_sector_enable;
	logic sram_select = 0, control_register_space = 0, pio_select = 0, security_lock = 0;
	logic sector_erase_cmd = 0, prog_req = 0, prog_active = 0, bulk_active = 0, seen;
	logic erase_done, erase_fail, erase_run, erase_abort, prog_grant;
	logic fail_arm = 0; // makes the flash model fail its next erase
	logic sram_enable, creg_enable, pio_enable;
	fesp_sect_t erase_target, sector_invalid;
	int n_errors = 0, compares = 0, cycles = 0, n;
	fesp_ctrl u_dut (.core_clk, .sys_rst, .flash_rst_n, .bus_addr, .bus_wr, .bus_rd,
		.bus_wdata, .bus_rdata, .main_sector_selects, .boot_sector_selects, .sram_select,
		.control_register_space, .pio_select, .main_sector_lock, .boot_sector_lock,
		.security_lock, .array_rdata, .sector_erase_cmd, .prog_req, .prog_active,
		.bulk_active, .erase_done, .erase_fail, .erase_target, .erase_run, .erase_abort,
		.prog_grant, .sector_invalid, .main_sector_enable, .boot_sector_enable,
		.sram_enable, .creg_enable, .pio_enable);
	fesp_flash_model u_model (.core_clk, .erase_run, .erase_abort, .bus_addr,
		.fail_arm, .array_rdata, .erase_done, .erase_fail);
	// 10 MHz core clock
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	// hang guard: the whole run needs about 6000 cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	// one comparison, widened to 16 bits
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one write strobe, launched and dropped on falling edges
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge core_clk);
		bus_wr = 1'b0;
	endtask : wr
	// one read strobe; data stands from the edge that saw the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge core_clk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge core_clk);
		bus_rd = 1'b0;
		d = bus_rdata;
	endtask : rd
	// sector erase command on the given main sector selects, optionally waiting out the window
	task automatic erase_cmd(input logic [7:0] sel, input bit wait_run);
		@(negedge core_clk);
		main_sector_selects = sel;
		sector_erase_cmd = 1'b1;
		@(negedge core_clk);
		sector_erase_cmd = 1'b0;
		n = 0;
		while (wait_run && erase_run !== 1'b1 && n < 1100) begin
			@(negedge core_clk);
			n++;
		end
	endtask : erase_cmd
	// counts cycles until the controller grants programming again
	task automatic wait_grant();
		n = 0;
		while (prog_grant !== 1'b1 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
	endtask : wait_grant
	// abort pulse may land on either of the next two cycles
	task automatic catch_abort();
		seen = erase_abort;
		@(negedge core_clk);
		seen = seen | erase_abort;
	endtask : catch_abort
	// select inputs, then let the combinational outputs settle
	task automatic sel(input logic [7:0] m, input logic [3:0] b, input logic [2:0] io);
		@(negedge core_clk);
		main_sector_selects = m;
		boot_sector_selects = b;
		{sram_select, control_register_space, pio_select} = io;
		#1;
	endtask : sel
	task automatic t_regs();
		control_register_space = 1'b1;
		main_sector_lock = 8'ha5;
		boot_sector_lock = 4'h6;
		security_lock = 1'b1;
		rd(16'h00c0, r1);
		chk("main lock", 16'h00a5, r1);
		rd(16'h00c2, r1);
		chk("sec lock", 16'h0086, r1);
		wr(16'h00c0, 8'h00);
		rd(16'h00c0, r1);
		chk("lock kept", 16'h00a5, r1);
		{control_register_space, security_lock, main_sector_lock, boot_sector_lock} = '0;
		$display("test regs done");
	endtask : t_regs
	task automatic t_prio();
		sel(8'h01, 4'h1, 3'b100);
		chk("sram win", 16'h4000, {sram_enable, creg_enable, pio_enable, boot_sector_enable,
			main_sector_enable});
		sel(8'h01, 4'h1, 3'b010);
		chk("creg win", 16'h2000, {creg_enable, pio_enable, boot_sector_enable,
			main_sector_enable});
		sel(8'h01, 4'h1, 3'b001);
		chk("pio win", 16'h1000, {pio_enable, boot_sector_enable, main_sector_enable});
		sel(8'h01, 4'h1, 3'b000);
		chk("boot win", 16'h0100, {boot_sector_enable, main_sector_enable});
		sel(8'h01, 4'h0, 3'b000);
		chk("main", 16'h0001, {sram_enable, boot_sector_enable, main_sector_enable});
		$display("test prio done");
	endtask : t_prio
	task automatic t_suspend();
		@(negedge core_clk);
		prog_req = 1'b1;
		main_sector_selects = 8'h08;
		wr(16'h0000, `FESP_CMD_SUSPEND);
		repeat (3) @(negedge core_clk);
		chk("suspend in read", 1, prog_grant);
		erase_cmd(8'h04, 0);
		repeat (20) @(negedge core_clk);
		wr(16'h0000, `FESP_CMD_SUSPEND);
		chk("run after suspend", 0, erase_run);
		repeat (2) @(negedge core_clk);
		chk("no program", 0, prog_grant);
		rd(16'h0000, r1);
		rd(16'h0000, r2);
		chk("suspended sector", `FESP_INVALID_DATA, r1);
		chk("toggle stopped", r1, r2);
		main_sector_selects = 8'h08;
		rd(16'h0012, r1);
		chk("other sector", 16'h0048, r1);
		main_sector_selects = 8'h04;
		wr(16'h0000, `FESP_CMD_RESUME);
		chk("resumed at once", 1, erase_run);
		rd(16'h0000, r1);
		rd(16'h0000, r2);
		chk("toggle again", 16'h0040, (r1 ^ r2) & 8'h40);
		chk("window over", 1, r1[`FESP_ST_WIN]);
		n = 0;
		while (erase_run === 1'b1 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		rd(16'h0000, r1);
		chk("read after erase", 16'h005a, r1);
		$display("test suspend done");
	endtask : t_suspend
	task automatic t_reset();
		erase_cmd(8'h02, 1);
		prog_active = 1'b1;
		wr(16'h0000, `FESP_CMD_RESET);
		chk("reset in program", 1, erase_run);
		prog_active = 1'b0;
		bulk_active = 1'b1;
		wr(16'h0000, `FESP_CMD_RESET);
		chk("reset in bulk", 1, erase_run);
		bulk_active = 1'b0;
		wr(16'h0000, `FESP_CMD_SUSPEND);
		chk("suspend in erase", 0, erase_run);
		wr(`FESP_UNLK1_ADDR, `FESP_UNLK1_DATA);
		wr(`FESP_UNLK2_ADDR, `FESP_UNLK2_DATA);
		wr(16'h0000, `FESP_CMD_RESET);
		catch_abort();
		chk("abort", 1, seen);
		chk("invalid sector", 16'h0002, sector_invalid);
		wait_grant();
		chk("back to read", 1, n >= 245 && n <= 252);
		$display("test reset done");
	endtask : t_reset
	task automatic t_lock();
		main_sector_lock = 8'h10;
		erase_cmd(8'h10, 0);
		chk("locked program", 0, prog_grant);
		repeat (1010) @(negedge core_clk);
		chk("locked erase", 0, {erase_run, erase_target});
		rd(16'h0033, r1);
		chk("locked verify", 16'h0069, r1);
		main_sector_lock = 8'h00;
		$display("test lock done");
	endtask : t_lock
	task automatic t_fail();
		fail_arm = 1'b1;
		erase_cmd(8'h20, 1);
		n = 0;
		while (erase_run === 1'b1 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		fail_arm = 1'b0;
		rd(16'h0000, r1);
		chk("error bit", 1, r1[`FESP_ST_ERR]);
		wr(16'h0000, `FESP_CMD_RESET); // host clears the error
		wait_grant();
		chk("error recovery", 1, n >= 248 && n <= 252);
		rd(16'h0000, r1);
		chk("read after error", 16'h005a, r1);
		$display("test fail done");
	endtask : t_fail
	task automatic t_pin();
		erase_cmd(8'h01, 1);
		@(negedge core_clk);
		flash_rst_n = 1'b0;
		catch_abort();
		chk("pin abort", 1, seen);
		repeat (`FESP_RST_CYC) @(negedge core_clk); // pin held the full 25 us
		flash_rst_n = 1'b1;
		chk("pin stops erase", 0, erase_run);
		wait_grant();
		chk("pin recovery", 1, n >= 248 && n <= 252);
		$display("test pin done");
	endtask : t_pin
	// main sequence after an 8-cycle reset
	initial begin
		repeat (8) @(negedge core_clk);
		sys_rst = 1'b0;
		t_regs();
		t_prio();
		t_suspend();
		t_reset();
		t_lock();
		t_fail();
		t_pin();
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
